//--- hdl/rms_top.sv
// rms_top: melody sequencer that reads melody words from program memory and drives a tone pin pair
// assumes an AXI4-Lite master on the register port and a program memory answering ROM_REQ with ROM_ACK
//
// Functional notes
// - playback starts on start command, tempo latched
// - fetch words autonomously, drive complementary tone pins
// - word: end bit15, duration 13:8, pitch 6:0
// - end word starts: raise end interrupt, stop after
// - start after end word continues seamlessly
// - no new start: stop after end word
// - control bit3 shows playback active
// - writing zero to bit3 stops immediately
// - tempo code 0 and 1 both 480 bpm
// - tone frequency is 65536/(N+2) hertz
// - pitch bits 6..2 zero give silence
// - duration code zero equals code one
// - note lasts 1.953125ms times (TP+1)(L+1)
// - note current at start command shortened slightly
// - melody suppresses buzzer on shared pins
// - reset clears active flag
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rms_cfg.svh"
module rms_top (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // program memory fetch port
    output logic             ROM_REQ,
    output logic [15:0]      ROM_ADDR,
    input  wire logic        ROM_ACK,
    input  wire logic [15:0] ROM_DATA,
    // buzzer sharing the pins
    input  wire logic        BUZZER_EN,
    input  wire logic        BUZZER_IN,
    output logic             BUZZER_STOP,
    // tone pins and interrupt
    output logic             TONE_OUT_P,
    output logic             TONE_OUT_N,
    output logic             IRQ
);

    localparam logic [10:0] SHORTEN_UNITS = 11'(`RMS_SHORTEN_UNITS);
    localparam logic [7:0]  UNIT_LAST     = 8'(`RMS_UNIT_TICKS - 64'h1);

    // register bus state
    logic                   aw_held_r;
    logic [7:0]             awaddr_r;
    logic                   w_held_r;
    logic [31:0]            wdata_r;
    logic [3:0]             wstrb_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [31:0]            rdata_r;
    logic [1:0]             rresp_r;
    logic                   wr_fire;
    logic                   rd_fire;
    logic                   wr_mapped;

    // software registers
    logic [3:0]             tempo_select_r;
    logic                   irq_stat_r;
    logic                   irq_mask_r;

    // sequencer state
    rms_pkg::rms_state_t    state_r;
    logic [15:0]            addr_r;
    rms_pkg::rms_word_t     word_r;
    logic [3:0]             tempo_play_r;
    logic                   pend_r;
    logic [15:0]            pend_addr_r;
    logic [10:0]            dur_cnt_r;
    logic [7:0]             pre_r;
    logic [25:0]            acc_r;
    logic                   tick_r;
    logic                   unit_tick;
    logic                   buzz_stop_r;
    rms_pkg::rms_pins_t     pins_r;

    logic                   start_wr;
    logic                   stop_wr;
    logic                   stat_clr;
    logic [15:0]            start_addr;
    logic                   end_event;
    logic                   note_done;
    logic [4:0]             tp_eff;
    logic [6:0]             len_eff;
    logic [10:0]            note_units;
    logic                   melody_active_flag;
    rms_pkg::rms_word_t     fetched;
    logic                   wave;
    logic                   silent;

    // write channel: address and data taken independently, committed together
    assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
    assign S_AXI_WREADY  = !w_held_r && !bvalid_r;
    assign S_AXI_BVALID  = bvalid_r;
    assign S_AXI_BRESP   = bresp_r;
    assign wr_fire       = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= 8'h00;
            w_held_r  <= 1'b0;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RMS_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                wdata_r  <= S_AXI_WDATA;
                wstrb_r  <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_mapped ? `RMS_RESP_OKAY : `RMS_RESP_DECERR;
            end else if (bvalid_r && S_AXI_BREADY) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_comb begin
        case (awaddr_r)
            `RMS_OFS_TEMPO, `RMS_OFS_CTRL, `RMS_OFS_START,
            `RMS_OFS_IRQ_STAT, `RMS_OFS_IRQ_MASK, `RMS_OFS_CUR_ADDR: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    // register write effects; byte lane 0 carries every narrow field
    assign start_wr   = wr_fire && (awaddr_r == `RMS_OFS_START) && (wstrb_r[0] || wstrb_r[1]);
    assign stop_wr    = wr_fire && (awaddr_r == `RMS_OFS_CTRL) && wstrb_r[0]
                        && !wdata_r[`RMS_CTRL_ACTIVE_BIT];
    assign stat_clr   = wr_fire && (awaddr_r == `RMS_OFS_IRQ_STAT) && wstrb_r[0]
                        && wdata_r[`RMS_IRQ_END_BIT];
    assign start_addr = {wstrb_r[1] ? wdata_r[15:8] : addr_r[15:8],
                         wstrb_r[0] ? wdata_r[7:0]  : addr_r[7:0]};

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tempo_select_r <= `RMS_TEMPO_RST;
            irq_mask_r     <= `RMS_MASK_RST;
        end else if (wr_fire && wstrb_r[0]) begin
            if (awaddr_r == `RMS_OFS_TEMPO) begin
                tempo_select_r <= wdata_r[3:0];
            end
            if (awaddr_r == `RMS_OFS_IRQ_MASK) begin
                irq_mask_r <= wdata_r[`RMS_IRQ_END_BIT];
            end
        end
    end

    // sticky end flag: a new end event beats a simultaneous clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_stat_r <= 1'b0;
        end else if (end_event) begin
            irq_stat_r <= 1'b1;
        end else if (stat_clr) begin
            irq_stat_r <= 1'b0;
        end
    end

    assign IRQ = irq_stat_r && irq_mask_r;

    // read channel: one cycle from address to data
    assign S_AXI_ARREADY      = !rvalid_r;
    assign S_AXI_RVALID       = rvalid_r;
    assign S_AXI_RDATA        = rdata_r;
    assign S_AXI_RRESP        = rresp_r;
    assign rd_fire            = S_AXI_ARVALID && !rvalid_r;
    assign melody_active_flag = (state_r != rms_pkg::ST_IDLE);

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= `RMS_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= `RMS_RESP_OKAY;
            case (S_AXI_ARADDR)
                `RMS_OFS_TEMPO:    rdata_r <= {28'h0000000, tempo_select_r};
                `RMS_OFS_CTRL:     rdata_r <= {28'h0000000, melody_active_flag, 3'h0};
                `RMS_OFS_START:    rdata_r <= {15'h0000, pend_r, pend_addr_r};
                `RMS_OFS_IRQ_STAT: rdata_r <= {31'h00000000, irq_stat_r};
                `RMS_OFS_IRQ_MASK: rdata_r <= {31'h00000000, irq_mask_r};
                `RMS_OFS_CUR_ADDR: rdata_r <= {16'h0000, addr_r};
                default: begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= `RMS_RESP_DECERR;
                end
            endcase
        end else if (rvalid_r && S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    // 131072 Hz tone tick by fractional accumulation of the 20 MHz clock
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            acc_r  <= 26'h0000000;
            tick_r <= 1'b0;
        end else if (acc_r + `RMS_TONE_TICK_HZ >= `RMS_CLK_HZ) begin
            acc_r  <= acc_r + `RMS_TONE_TICK_HZ - `RMS_CLK_HZ;
            tick_r <= 1'b1;
        end else begin
            acc_r  <= acc_r + `RMS_TONE_TICK_HZ;
            tick_r <= 1'b0;
        end
    end

    // duration unit of 1.953125 ms, realigned at every note load
    assign unit_tick = tick_r && (pre_r == UNIT_LAST);

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pre_r <= 8'h00;
        end else if (state_r != rms_pkg::ST_PLAY) begin
            pre_r <= 8'h00;
        end else if (tick_r) begin
            pre_r <= unit_tick ? 8'h00 : pre_r + 8'h01;
        end
    end

    // note length in units; codes below one are raised to one
    assign fetched    = rms_pkg::rms_word_t'(ROM_DATA);
    assign tp_eff     = (tempo_play_r == 4'h0) ? 5'h02 : {1'b0, tempo_play_r} + 5'h01;
    assign len_eff    = (fetched.duration_code == 6'h00) ? 7'h02
                        : {1'b0, fetched.duration_code} + 7'h01;
    assign note_units = {6'h00, tp_eff} * {4'h0, len_eff};
    assign note_done  = (state_r == rms_pkg::ST_PLAY) && unit_tick && (dur_cnt_r <= 11'h001);
    assign end_event  = (state_r == rms_pkg::ST_FETCH) && ROM_ACK && fetched.end_flag;

    assign ROM_REQ  = (state_r == rms_pkg::ST_FETCH);
    assign ROM_ADDR = addr_r;

    // sequencer
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_r      <= rms_pkg::ST_IDLE;
            addr_r       <= 16'h0000;
            word_r       <= '0;
            tempo_play_r <= `RMS_TEMPO_RST;
            pend_r       <= 1'b0;
            pend_addr_r  <= 16'h0000;
            dur_cnt_r    <= 11'h000;
        end else if (stop_wr && melody_active_flag) begin
            // forced stop discards the position; a later start names a new address
            state_r <= rms_pkg::ST_IDLE;
            pend_r  <= 1'b0;
        end else begin
            case (state_r)
                rms_pkg::ST_IDLE: begin
                    if (start_wr) begin
                        addr_r       <= start_addr;
                        tempo_play_r <= tempo_select_r;
                        state_r      <= rms_pkg::ST_FETCH;
                    end
                end
                rms_pkg::ST_FETCH: begin
                    if (start_wr) begin
                        pend_r      <= 1'b1;
                        pend_addr_r <= start_addr;
                    end
                    if (ROM_ACK) begin
                        word_r    <= fetched;
                        dur_cnt_r <= note_units;
                        state_r   <= rms_pkg::ST_PLAY;
                    end
                end
                rms_pkg::ST_PLAY: begin
                    if (note_done) begin
                        if (pend_r || start_wr) begin
                            // queued start wins over the end flag, so no silence is inserted
                            addr_r       <= pend_r ? pend_addr_r : start_addr;
                            tempo_play_r <= tempo_select_r;
                            pend_r       <= 1'b0;
                            state_r      <= rms_pkg::ST_FETCH;
                        end else if (word_r.end_flag) begin
                            state_r <= rms_pkg::ST_IDLE;
                        end else begin
                            addr_r  <= addr_r + 16'h0001;
                            state_r <= rms_pkg::ST_FETCH;
                        end
                    end else begin
                        if (start_wr) begin
                            pend_r      <= 1'b1;
                            pend_addr_r <= start_addr;
                            // the running note loses one unit when a start is taken
                            if (dur_cnt_r > SHORTEN_UNITS) begin
                                dur_cnt_r <= dur_cnt_r - SHORTEN_UNITS;
                            end
                        end else if (unit_tick) begin
                            dur_cnt_r <= dur_cnt_r - 11'h001;
                        end
                    end
                end
                default: state_r <= rms_pkg::ST_IDLE;
            endcase
        end
    end

    rms_tone_gen u_tone (
        .clk    (CLOCK),
        .rst    (RST),
        .tick   (tick_r),
        .run    (state_r == rms_pkg::ST_PLAY),
        .pitch  (word_r.pitch_code),
        .wave   (wave),                                             
        .silent (silent)
    );

    // pin pair: melody owns the pins while active, buzzer only when idle
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pins_r <= '0;
        end else if (state_r == rms_pkg::ST_PLAY) begin
            pins_r.p <= wave;
            pins_r.n <= silent ? 1'b0 : ~wave;
        end else if (state_r == rms_pkg::ST_IDLE) begin
            pins_r.p <= BUZZER_EN && BUZZER_IN;
            pins_r.n <= BUZZER_EN && !BUZZER_IN;
        end
    end

    assign TONE_OUT_P = pins_r.p;
    assign TONE_OUT_N = pins_r.n;

    // tells the buzzer to drop its enable when a melody is started
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            buzz_stop_r <= 1'b0;
        end else begin
            buzz_stop_r <= start_wr && (state_r == rms_pkg::ST_IDLE);
        end
    end

    assign BUZZER_STOP = buzz_stop_r;

endmodule : rms_top

//--- hdl/rms_cfg.svh
// rms_cfg.svh: register offsets, field positions, reset values and timing counts of the melody sequencer
// assumes a 20 MHz system clock and a 32-bit AXI4-Lite register port with byte addressing
`ifndef RMS_CFG_SVH
`define RMS_CFG_SVH

// register byte offsets
`define RMS_ADDR_W          8
`define RMS_OFS_TEMPO       8'h00
`define RMS_OFS_CTRL        8'h04
`define RMS_OFS_START       8'h08
`define RMS_OFS_IRQ_STAT    8'h0C
`define RMS_OFS_IRQ_MASK    8'h10
`define RMS_OFS_CUR_ADDR    8'h14

// field positions and reset values
`define RMS_CTRL_ACTIVE_BIT 3
`define RMS_IRQ_END_BIT     0
`define RMS_TEMPO_RST       4'h0
`define RMS_MASK_RST        1'h0

// AXI responses
`define RMS_RESP_OKAY       2'h0
`define RMS_RESP_DECERR     2'h3

// timing
`define RMS_CLK_HZ          26'h1312D00
`define RMS_TONE_TICK_HZ    26'h0020000
`define RMS_UNIT_NS         64'h1DCD65
`define RMS_UNIT_TICKS      ((`RMS_UNIT_NS * 64'h20000) / 64'h3B9ACA00)
`define RMS_SHORTEN_NS      64'h2DC6C0
`define RMS_SHORTEN_UNITS   (((`RMS_SHORTEN_NS / `RMS_UNIT_NS) < 64'h1) ? 64'h1 : (`RMS_SHORTEN_NS / `RMS_UNIT_NS))

`endif

//--- hdl/rms_pkg.sv
// rms_pkg: types shared by the melody sequencer files
// assumes rms_cfg.svh supplies all numeric constants
package rms_pkg;

    // one 16-bit melody word as fetched from program memory
    typedef struct packed {
        logic       end_flag;
        logic       spare_hi;
        logic [5:0] duration_code;
        logic       spare_lo;
        logic [6:0] pitch_code;
    } rms_word_t;

    // complementary drive pair
    typedef struct packed {
        logic p;
        logic n;
    } rms_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_PLAY
    } rms_state_t;

endpackage : rms_pkg

//--- hdl/rms_tone_gen.sv
// rms_tone_gen: square wave of 65536/(N+2) Hz from a 131072 Hz tick
// assumes tick is a one-cycle pulse and pitch is stable while run is high
`timescale 1ns/1ps
module rms_tone_gen (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic [6:0] pitch,
    output logic            wave,
    output logic            silent
);
    logic [7:0] cnt_r;
    logic       wave_r;

    assign silent = (pitch[6:2] == 5'h00);
    assign wave   = wave_r & ~silent;

    // half period is N+2 ticks, so a full period is 2(N+2)/131072 s
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= 8'h00;
            wave_r <= 1'b0;
        end else if (!run || silent) begin
            cnt_r  <= 8'h00;
            wave_r <= 1'b0;
        end else if (tick) begin
            if (cnt_r == {1'b0, pitch} + 8'h01) begin
                cnt_r  <= 8'h00;
                wave_r <= ~wave_r;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

endmodule : rms_tone_gen

//--- tb/rms_rom_model.sv
// rms_rom_model: program memory answering fetch requests of the melody sequencer
// assumes the bench fills mem and sets lat (extra wait cycles) before a fetch
`timescale 1ns/1ps
module rms_rom_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req,
    input  wire logic [15:0] addr,
    output logic             ack,
    output logic [15:0]      data
);
    logic [15:0] mem [0:255];
    int          lat;
    int          wait_cnt;

    // unfilled words are silent end words, so a stray fetch stops the melody unless a start is pending
    initial begin
        lat = 0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h8000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack      <= 1'b0;
            data     <= 16'hA5A5;
            wait_cnt <= 0;
        end else if (req && !ack && wait_cnt >= lat) begin
            ack      <= 1'b1;
            data     <= mem[addr[7:0]];
            wait_cnt <= 0;
        end else begin
            ack      <= 1'b0;
            // released bus inverts the data every cycle instead of holding the last word
            data     <= ~data;
            wait_cnt <= (req && !ack) ? wait_cnt + 1 : 0;
        end
    end
endmodule : rms_rom_model

//--- tb/rms_top_checker.sv
// rms_top_checker: assertions on the melody sequencer ports
// assumes one clock domain with asynchronous active-high reset
`timescale 1ns/1ps
module rms_top_checker (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        ROM_REQ,
    input wire logic [15:0] ROM_ADDR,
    input wire logic        ROM_ACK,
    input wire logic        BUZZER_STOP,
    input wire logic        TONE_OUT_P,
    input wire logic        TONE_OUT_N,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    a_addr_held: assert property (ROM_REQ && !ROM_ACK |=> ROM_REQ && $stable(ROM_ADDR))
        else $error("fetch address moved before acknowledge");
    a_req_release: assert property (ROM_REQ && ROM_ACK |=> !ROM_REQ)
        else $error("fetch request held after acknowledge");
    a_pins_frozen: assert property (ROM_REQ && $past(ROM_REQ) |-> $stable({TONE_OUT_P, TONE_OUT_N}))
        else $error("tone pins changed during fetch");
    a_pins_exclusive: assert property (!(TONE_OUT_P && TONE_OUT_N))
        else $error("both tone pins high");
    a_irq_cause: assert property ($rose(IRQ) |-> $past(ROM_ACK) || S_AXI_BVALID)
        else $error("interrupt rose without fetch or register write");
    a_stop_pulse: assert property (BUZZER_STOP |=> !BUZZER_STOP [*2])
        else $error("buzzer stop longer than one cycle");
    a_stop_fetch: assert property (BUZZER_STOP |-> ##[0:1] ROM_REQ)
        else $error("start taken without a fetch");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered in one cycle");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
                                     |=> ##1 S_AXI_BVALID)
        else $error("write not answered in two cycles");
endmodule : rms_top_checker

bind rms_top rms_top_checker u_chk (.*);

//--- tb/rms_top_tb.sv
// rms_top_tb: self-checking bench for the melody sequencer
// assumes rms_rom_model as program memory and the bound checker
`timescale 1ns/1ps
`include "rms_cfg.svh"
module rms_top_tb;
    // clocks per 1.953125 ms unit at 20 MHz
    localparam real UNIT = 256.0 * 20.0e6 / 131072.0;
    logic        CLOCK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic        ROM_REQ, ROM_ACK, BUZZER_EN, BUZZER_IN, BUZZER_STOP, TONE_OUT_P, TONE_OUT_N, IRQ;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic [15:0] ROM_ADDR, ROM_DATA;
    logic        stop_seen;
    int          fails, n_checks, cyc;

    rms_top u_dut (.*);
    rms_rom_model u_rom (.clk(CLOCK), .rst(RST), .req(ROM_REQ), .addr(ROM_ADDR), .ack(ROM_ACK),
                         .data(ROM_DATA));

    always #25 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (BUZZER_STOP) stop_seen <= 1'b1;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string what, input real lo, input real hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[ERR] %s expected %0.1f..%0.1f seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw, w, b;
        aw = 0;
        w = 0;
        b = 0;
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        while (!b) begin
            @(negedge CLOCK);
            b = aw && w && S_AXI_BVALID;
            r = S_AXI_BRESP;
            aw = aw || (S_AXI_AWVALID && S_AXI_AWREADY);
            w = w || (S_AXI_WVALID && S_AXI_WREADY);
            @(posedge CLOCK);
            if (aw && S_AXI_AWVALID) S_AXI_AWVALID <= 1'b0;
            if (w && S_AXI_WVALID) S_AXI_WVALID <= 1'b0;
        end
    endtask : axi_wr

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk("write resp", 32'(er), 32'(r));
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        bit          ar, rv;
        logic [31:0] d;
        logic [1:0]  r;
        ar = 0;
        rv = 0;
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        while (!rv) begin
            @(negedge CLOCK);
            rv = ar && S_AXI_RVALID;
            d = S_AXI_RDATA;
            r = S_AXI_RRESP;
            ar = ar || (S_AXI_ARVALID && S_AXI_ARREADY);
            @(posedge CLOCK);
            if (ar && S_AXI_ARVALID) S_AXI_ARVALID <= 1'b0;
        end
        chk(what, exp, d);
        chk("read resp", 32'(er), 32'(r));
    endtask : rd_chk

    task automatic wait_hi(input bit ack, output int t);
        bit hit;
        hit = 0;
        for (int n = 0; n < 200000 && !hit; n++) begin
            @(negedge CLOCK);
            hit = ack ? ROM_ACK : ROM_REQ;
            t = cyc;
            @(posedge CLOCK);
        end
    endtask : wait_hi

    // waits for a tone edge and checks the pair stays complementary
    task automatic wait_flip(output int t);
        logic p;
        @(negedge CLOCK);
        p = TONE_OUT_P;
        for (int n = 0; n < 5000 && TONE_OUT_P === p; n++) @(negedge CLOCK);
        t = cyc;
        chk("pin pair", 32'(!TONE_OUT_P), 32'(TONE_OUT_N));
        @(posedge CLOCK);
    endtask : wait_flip

    task automatic outs(input string what, input logic [2:0] exp);
        repeat (2) @(negedge CLOCK);
        chk(what, 32'(exp), 32'({TONE_OUT_P, TONE_OUT_N, IRQ}));
        @(posedge CLOCK);
    endtask : outs

    task automatic t_regs();
        rd_chk("tempo", `RMS_OFS_TEMPO, 32'h0, `RMS_RESP_OKAY);
        rd_chk("ctrl", `RMS_OFS_CTRL, 32'h0, `RMS_RESP_OKAY);
        rd_chk("status", `RMS_OFS_IRQ_STAT, 32'h0, `RMS_RESP_OKAY);
        rd_chk("mask", `RMS_OFS_IRQ_MASK, 32'h0, `RMS_RESP_OKAY);
        wr(`RMS_OFS_TEMPO, 32'hFFFFFFFF, `RMS_RESP_OKAY);
        rd_chk("tempo rw", `RMS_OFS_TEMPO, 32'hF, `RMS_RESP_OKAY);
        wr(`RMS_OFS_TEMPO, 32'h0, `RMS_RESP_OKAY);
        wr(8'h40, 32'h1, `RMS_RESP_DECERR);
        rd_chk("unmapped", 8'h40, 32'h0, `RMS_RESP_DECERR);
        outs("idle", 3'h0);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_buzzer();
        BUZZER_EN <= 1'b1;
        BUZZER_IN <= 1'b1;
        repeat (2) @(posedge CLOCK);
        outs("buzz high", 3'h4);
        BUZZER_IN <= 1'b0;
        repeat (2) @(posedge CLOCK);
        outs("buzz low", 3'h2);
        $display("t_buzzer done");
    endtask : t_buzzer

    task automatic t_play();
        int t0, t1, e0, e1;
        u_rom.mem[8'h10] = 16'h0004;
        u_rom.mem[8'h11] = 16'h8003;
        u_rom.mem[8'h20] = 16'h4085;
        u_rom.lat = 3;
        wr(`RMS_OFS_START, 32'h10, `RMS_RESP_OKAY);
        wait_hi(1'b0, t0);
        chk("fetch addr", 32'h10, 32'(ROM_ADDR));
        wait_hi(1'b1, t0);
        chk("buzzer stop", 32'h1, 32'(stop_seen));
        rd_chk("active", `RMS_OFS_CTRL, 32'h8, `RMS_RESP_OKAY);
        wr(`RMS_OFS_TEMPO, 32'hF, `RMS_RESP_OKAY);
        wait_flip(e0);
        wait_flip(e1);
        chk_rng("half period", 912.0, 919.0, e1 - e0);
        wait_hi(1'b0, t1);
        chk_rng("note length", 4.0 * UNIT - 200.0, 4.0 * UNIT + 200.0, t1 - t0);
        chk("next addr", 32'h11, 32'(ROM_ADDR));
        wr(`RMS_OFS_TEMPO, 32'h0, `RMS_RESP_OKAY);
        u_rom.lat = 0;
        wait_hi(1'b1, t0);
        outs("silent", 3'h0);
        rd_chk("end status", `RMS_OFS_IRQ_STAT, 32'h1, `RMS_RESP_OKAY);
        wr(`RMS_OFS_IRQ_MASK, 32'h1, `RMS_RESP_OKAY);
        outs("irq on", 3'h1);
        wr(`RMS_OFS_START, 32'h20, `RMS_RESP_OKAY);
        wr(`RMS_OFS_IRQ_STAT, 32'h1, `RMS_RESP_OKAY);
        outs("irq clear", 3'h0);
        wait_hi(1'b0, t1);
        chk_rng("short note", 3.0 * UNIT - 200.0, 3.0 * UNIT + 200.0, t1 - t0);
        chk("redirect", 32'h20, 32'(ROM_ADDR));
        rd_chk("no gap", `RMS_OFS_CTRL, 32'h8, `RMS_RESP_OKAY);
        wait_flip(e0);
        wait_flip(e1);
        chk_rng("spare bits", 1064.0, 1073.0, e1 - e0);
        wr(`RMS_OFS_START, 32'h30, `RMS_RESP_OKAY);
        wr(`RMS_OFS_CTRL, 32'h0, `RMS_RESP_OKAY);
        rd_chk("stopped", `RMS_OFS_CTRL, 32'h0, `RMS_RESP_OKAY);
        outs("buzzer back", 3'h2);
        $display("t_play done");
    endtask : t_play

    initial begin
        CLOCK = 1'b0;
        RST = 1'b1;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
        S_AXI_WSTRB = 4'hF;
        {BUZZER_EN, BUZZER_IN, stop_seen} = 3'h0;
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        t_regs();
        t_buzzer();
        t_play();
        stop_test();
    end

    initial begin
        repeat (400000) @(posedge CLOCK);
        fails++;
        $display("[ERR] watchdog expected finish seen hang");
        stop_test();
    end
endmodule : rms_top_tb
